// >>> src/lpm_pkg.sv
// Purpose: Shared constants, register map and helpers of the light and proximity sequencer.
// Assumes: 20 MHz system clock, 32-bit Avalon-MM register bus with 8-bit registers.
// Notes: Each register occupies one aligned word; byte address is four times its index.
package lpm_pkg;

    // Register indices and byte addresses.
    localparam int REG_IDX_CMD1 = 0;
    localparam int REG_IDX_CMD2 = 1;
    localparam int REG_IDX_DATA_LSB = 2;
    localparam int REG_IDX_DATA_MSB = 3;
    localparam int REG_IDX_CTRL = 4;
    localparam int REG_IDX_EXT_TRIG = 5;
    localparam int REG_IDX_STATUS = 6;
    localparam int ADDR_W = 5;
    localparam logic [ADDR_W-1:0] ADDR_CMD1 = 5'(REG_IDX_CMD1 * 4);
    localparam logic [ADDR_W-1:0] ADDR_CMD2 = 5'(REG_IDX_CMD2 * 4);
    localparam logic [ADDR_W-1:0] ADDR_DATA_LSB = 5'(REG_IDX_DATA_LSB * 4);
    localparam logic [ADDR_W-1:0] ADDR_DATA_MSB = 5'(REG_IDX_DATA_MSB * 4);
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 5'(REG_IDX_CTRL * 4);
    localparam logic [ADDR_W-1:0] ADDR_EXT_TRIG = 5'(REG_IDX_EXT_TRIG * 4);
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 5'(REG_IDX_STATUS * 4);

    // Reset values.
    localparam logic [7:0] CMD1_RST = 8'h00;
    localparam logic [7:0] CMD2_RST = 8'h00;
    localparam logic [15:0] DATA_RST = 16'h0000;

    // Field positions.
    localparam int OP_LSB = 5;
    localparam int CUR_LSB = 6;
    localparam int FREQ_LSB = 4;
    localparam int RES_LSB = 2;
    localparam int RANGE_LSB = 0;
    localparam int CTRL_EXT_BIT = 0;
    localparam int OP_CONT_BIT = 2;

    // Operation codes; bit 2 selects continuous, bits 1:0 the source.
    localparam logic [2:0] OP_PDOWN = 3'h0;
    localparam logic [2:0] OP_RESERVED = 3'h4;
    localparam logic [1:0] SRC_PROX = 2'h3;

    // Modulation frequency codes.
    localparam logic [1:0] FREQ_DC = 2'h0;
    localparam logic [1:0] FREQ_MOD = 2'h3;

    // Resolution codes.
    localparam logic [1:0] RES_16 = 2'h0;
    localparam logic [1:0] RES_12 = 2'h1;
    localparam logic [1:0] RES_8 = 2'h2;

    // Timing.
    localparam int CLK_KHZ = 20000;
    localparam int MOD_FREQ_KHZ = 360;
    localparam int MOD_HALF_CYC = CLK_KHZ / (2 * MOD_FREQ_KHZ);
    localparam int CYC_16_DEF = 65536;
    localparam logic [16:0] CYC_12 = 17'h01000;
    localparam logic [16:0] CYC_8 = 17'h00100;
    localparam logic [16:0] CYC_4 = 17'h00010;

    // Integration length in oscillator cycles for a resolution code.
    function automatic logic [16:0] lpm_res_cycles(input logic [1:0] res, input logic [16:0] cyc16);
        case (res)
            RES_16: lpm_res_cycles = cyc16;
            RES_12: lpm_res_cycles = CYC_12;
            RES_8: lpm_res_cycles = CYC_8;
            default: lpm_res_cycles = CYC_4;
        endcase
    endfunction : lpm_res_cycles

    // Largest result representable at a resolution code.
    function automatic logic [15:0] lpm_res_max(input logic [1:0] res);
        case (res)
            RES_16: lpm_res_max = 16'hFFFF;
            RES_12: lpm_res_max = 16'h0FFF;
            RES_8: lpm_res_max = 16'h00FF;
            default: lpm_res_max = 16'h000F;
        endcase
    endfunction : lpm_res_max

    // True for the six measuring operation codes.
    function automatic logic lpm_op_measures(input logic [2:0] op);
        lpm_op_measures = (op != OP_PDOWN) && (op != OP_RESERVED);
    endfunction : lpm_op_measures

endpackage : lpm_pkg

// >>> src/lpm_conv_if.sv
// Purpose: Carries conversion control and results between sequencer and integrator.
// Assumes: One clock domain.
// Notes: Start, abort, stop and done are one-cycle pulses.
`timescale 1ns/1ps
interface lpm_conv_if;
    logic start;
    logic abort;
    logic stop;
    logic ext_mode;
    logic [1:0] res;
    logic done;
    logic [15:0] result;
    modport seq (output start, output abort, output stop, output ext_mode, output res,
                 input done, input result);
    modport integ (input start, input abort, input stop, input ext_mode, input res,
                   output done, output result);
endinterface : lpm_conv_if

// >>> src/lpm_integrator.sv
// Purpose: Times one integration and counts charge-balance pulses into a result.
// Assumes: i_adc_pulse is one cycle per charge packet, synchronous to the clock.
// Notes: Result saturates at the largest value of the selected width.
`timescale 1ns/1ps
module lpm_integrator
    import lpm_pkg::*;
#(
    parameter int P_CYC_16 = CYC_16_DEF
) (
    // Clock and reset.
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    // Front end.
    input wire logic i_adc_pulse,
    // Sequencer side.
    lpm_conv_if.integ conv
);

    if (P_CYC_16 < 2 || P_CYC_16 > 65536) begin : g_chk
        $error("P_CYC_16 out of range");
    end

    logic running_r;
    logic ext_r;
    logic [16:0] target_r;
    logic [15:0] max_r;
    logic [16:0] cyc_r;
    logic [15:0] acc_r;
    logic done_r;
    logic [15:0] result_r;
    logic finish;

    // Internal timing ends after the cycle count; external timing at the stop command.
    assign finish = running_r && (ext_r ? conv.stop : (cyc_r + 17'h00001 == target_r));

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            running_r <= 1'b0;
            ext_r <= 1'b0;
            target_r <= 17'h00000;
            max_r <= 16'h0000;
            cyc_r <= 17'h00000;
            acc_r <= 16'h0000;
        end else if (conv.start) begin
            running_r <= 1'b1;
            ext_r <= conv.ext_mode;
            target_r <= lpm_res_cycles(conv.res, 17'(P_CYC_16));
            max_r <= lpm_res_max(conv.res);
            cyc_r <= 17'h00000;
            acc_r <= 16'h0000;
        end else if (conv.abort || finish) begin
            running_r <= 1'b0;
        end else if (running_r) begin
            if (cyc_r != 17'h1FFFF) begin
                cyc_r <= cyc_r + 17'h00001;
            end
            if (i_adc_pulse && acc_r != max_r) begin
                acc_r <= acc_r + 16'h0001;
            end
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            done_r <= 1'b0;
            result_r <= DATA_RST;
        end else begin
            done_r <= finish && !conv.abort;
            if (finish && !conv.abort) begin
                result_r <= (i_adc_pulse && acc_r != max_r) ? acc_r + 16'h0001 : acc_r;
            end
        end
    end

    assign conv.done = done_r;
    assign conv.result = result_r;

endmodule : lpm_integrator

// >>> src/lpm_ir_driver.sv
// Purpose: Gates the IR LED driver and applies its current and modulation settings.
// Assumes: Settings are stable while the driver is enabled.
// Notes: Codes other than DC and full-rate modulation drive steady DC.
`timescale 1ns/1ps
module lpm_ir_driver
    import lpm_pkg::*;
#(
    parameter int P_HALF_CYC = MOD_HALF_CYC
) (
    // Clock and reset.
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    // Control.
    input wire logic i_enable,
    input wire logic [1:0] i_freq_sel,
    input wire logic [1:0] i_cur_sel,
    // LED pins.
    output logic o_drive,
    output logic [1:0] o_cur_sel
);

    if (P_HALF_CYC < 1 || P_HALF_CYC > 255) begin : g_chk
        $error("P_HALF_CYC out of range");
    end

    logic [7:0] half_r;
    logic phase_r;

    // Equal on and off halves give the fifty percent duty.
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            half_r <= 8'h00;
            phase_r <= 1'b1;
        end else if (!i_enable || i_freq_sel != FREQ_MOD) begin
            half_r <= 8'h00;
            phase_r <= 1'b1;
        end else if (half_r == 8'(P_HALF_CYC - 1)) begin
            half_r <= 8'h00;
            phase_r <= ~phase_r;
        end else begin
            half_r <= half_r + 8'h01;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_drive <= 1'b0;
            o_cur_sel <= 2'h0;
        end else begin
            o_drive <= i_enable && (i_freq_sel == FREQ_MOD ? phase_r : 1'b1);
            o_cur_sel <= i_cur_sel;
        end
    end

endmodule : lpm_ir_driver

// >>> src/lpm_ctrl.sv
// Purpose: Measurement sequencer and register file of the light and proximity sensor.
// Assumes: Avalon-MM master holds each request until waitrequest is seen low.
// Notes: Every bus access answers in exactly two cycles.
//
// Added by the designer: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps
module lpm_ctrl
    import lpm_pkg::*;
#(
    parameter int P_CYC_16 = CYC_16_DEF,
    parameter int P_HALF_CYC = MOD_HALF_CYC
) (
    // Clock and reset.
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    // Avalon-MM slave.
    input wire logic [ADDR_W-1:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    // Converter front end.
    input wire logic i_adc_pulse,
    output logic o_adc_active,
    output logic [1:0] o_adc_src,
    output logic [1:0] o_range_sel,
    // IR LED driver.
    output logic o_ir_led_drive_out,
    output logic [1:0] o_led_current_sel
);

    typedef enum logic [1:0] {
        ST_PDOWN,
        ST_ARM,
        ST_INTEG
    } lpm_state_e;

    ////////////////////////////////////////////////////////////////////////////
    // Declarations.

    lpm_conv_if conv ();

    lpm_state_e state_r;
    lpm_state_e state_nxt;
    logic [7:0] cmd1_r;
    logic [7:0] cmd2_r;
    logic [15:0] data_r;
    logic ext_mode_r;
    logic ext_act_r;
    logic [2:0] op_act_r;
    logic [2:0] op_nxt;
    logic wait_r;
    logic [31:0] rdata_r;
    logic adc_active_r;
    logic [1:0] adc_src_r;
    logic [1:0] range_r;
    logic prox_en_r;
    logic wr_fire;
    logic wr_cmd1;
    logic wr_trig;
    logic [2:0] wr_op;
    logic conv_start;
    logic conv_abort;
    logic conv_stop;
    logic [7:0] rd_byte;

    ////////////////////////////////////////////////////////////////////////////
    // Bus slave. The first cycle of a request drops waitrequest and captures
    // read data; the second cycle is the one the master samples, and a write
    // takes effect there. Only byte lane 0 carries the 8-bit registers.

    assign wr_fire = i_avs_write && !wait_r && i_avs_byteenable[0];
    assign wr_cmd1 = wr_fire && i_avs_address == ADDR_CMD1;
    assign wr_trig = wr_fire && i_avs_address == ADDR_EXT_TRIG;
    assign wr_op = i_avs_writedata[OP_LSB +: 3];

    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            wait_r <= 1'b1;
        end else begin
            wait_r <= !((i_avs_read || i_avs_write) && wait_r);
        end
    end

    always_comb begin
        case (i_avs_address)
            ADDR_CMD1: rd_byte = cmd1_r;
            ADDR_CMD2: rd_byte = cmd2_r;
            ADDR_DATA_LSB: rd_byte = data_r[7:0];
            ADDR_DATA_MSB: rd_byte = data_r[15:8];
            ADDR_CTRL: rd_byte = {7'h00, ext_mode_r};
            ADDR_STATUS: rd_byte = {2'h0, ext_act_r, op_act_r, state_r == ST_ARM,
                                    state_r == ST_INTEG};
            default: rd_byte = 8'h00;
        endcase
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rdata_r <= 32'h00000000;
        end else if (i_avs_read && wait_r) begin
            rdata_r <= {24'h000000, rd_byte};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Command registers. They keep their value until software rewrites them;
    // the unused low bits of the first one always read back as zero.

    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cmd1_r <= CMD1_RST;
        end else if (wr_cmd1) begin
            cmd1_r <= {wr_op, 5'h00};
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cmd2_r <= CMD2_RST;
        end else if (wr_fire && i_avs_address == ADDR_CMD2) begin
            cmd2_r <= i_avs_writedata[7:0];
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ext_mode_r <= 1'b0;
        end else if (wr_fire && i_avs_address == ADDR_CTRL) begin
            ext_mode_r <= i_avs_writedata[CTRL_EXT_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer. A command write always wins over whatever the current state
    // would do, so a running conversion is dropped without touching the data.

    always_comb begin
        state_nxt = state_r;
        op_nxt = op_act_r;
        conv_start = 1'b0;
        conv_abort = 1'b0;
        conv_stop = 1'b0;
        if (wr_cmd1) begin
            conv_abort = (state_r == ST_INTEG);
            op_nxt = wr_op;
            if (lpm_op_measures(wr_op)) begin
                if (ext_mode_r) begin
                    state_nxt = ST_ARM;
                end else begin
                    state_nxt = ST_INTEG;
                    conv_start = 1'b1;
                end
            end else begin
                state_nxt = ST_PDOWN;
            end
        end else begin
            case (state_r)
                ST_PDOWN: begin
                    state_nxt = ST_PDOWN;
                end
                ST_ARM: begin
                    if (wr_trig) begin
                        state_nxt = ST_INTEG;
                        conv_start = 1'b1;
                    end
                end
                ST_INTEG: begin
                    // In external timing the trigger that ends one period opens the next when the operation is continuous.
                    if (ext_act_r && wr_trig) begin
                        conv_stop = 1'b1;
                        conv_start = op_act_r[OP_CONT_BIT];
                    end
                    if (conv.done) begin
                        if (!op_act_r[OP_CONT_BIT]) begin
                            state_nxt = ST_PDOWN;
                        end else if (!ext_act_r) begin
                            conv_start = 1'b1;
                        end
                    end
                end
                default: begin
                    state_nxt = ST_PDOWN;
                end
            endcase
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_r <= ST_PDOWN;
            op_act_r <= OP_PDOWN;
        end else begin
            state_r <= state_nxt;
            op_act_r <= op_nxt;
        end
    end

    // The sequencer's timing mode is latched at each command write, while the
    // integrator takes ext_mode_r at every start, continuous restarts included.
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ext_act_r <= 1'b0;
        end else if (wr_cmd1) begin
            ext_act_r <= ext_mode_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Result data. Every completed conversion overwrites it; nothing else does.

    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            data_r <= DATA_RST;
        end else if (conv.done) begin
            data_r <= conv.result;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Front end settings, taken at each start and held through the conversion.

    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            adc_src_r <= 2'h0;
            range_r <= 2'h0;
            prox_en_r <= 1'b0;
        end else begin
            if (conv_start) begin
                adc_src_r <= op_nxt[1:0];
                range_r <= cmd2_r[RANGE_LSB +: 2];
            end
            prox_en_r <= (state_nxt == ST_INTEG) && (conv_start ?
                         op_nxt[1:0] == SRC_PROX : prox_en_r);
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            adc_active_r <= 1'b0;
        end else begin
            adc_active_r <= (state_nxt == ST_INTEG);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Integrator.

    assign conv.start = conv_start;
    assign conv.abort = conv_abort;
    assign conv.stop = conv_stop;
    assign conv.ext_mode = ext_mode_r;
    assign conv.res = cmd2_r[RES_LSB +: 2];

    lpm_integrator #(
        .P_CYC_16(P_CYC_16)
    ) u_integ (
        .i_ref_clk(i_ref_clk),
        .i_rst_b(i_rst_b),
        .i_adc_pulse(i_adc_pulse),
        .conv(conv.integ)
    );

    ////////////////////////////////////////////////////////////////////////////
    // IR LED driver.

    lpm_ir_driver #(
        .P_HALF_CYC(P_HALF_CYC)
    ) u_ir (
        .i_ref_clk(i_ref_clk),
        .i_rst_b(i_rst_b),
        .i_enable(prox_en_r),
        .i_freq_sel(cmd2_r[FREQ_LSB +: 2]),
        .i_cur_sel(cmd2_r[CUR_LSB +: 2]),
        .o_drive(o_ir_led_drive_out),
        .o_cur_sel(o_led_current_sel)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Outputs.

    assign o_avs_readdata = rdata_r;
    assign o_avs_waitrequest = wait_r;
    assign o_adc_active = adc_active_r;
    assign o_adc_src = adc_src_r;
    assign o_range_sel = range_r;

endmodule : lpm_ctrl

// >>> sim/lpm_ctrl_asserts.sv
// Purpose: Port assertions of the light and proximity sequencer.
// Assumes: The bus master leaves an idle cycle between requests.
// Notes: LED runs over eight cycles are treated as steady drive.
`timescale 1ns/1ps
module lpm_ctrl_asserts
    import lpm_pkg::*;
#(
    parameter int P_HALF_CYC = MOD_HALF_CYC
) (
    // Clock and reset.
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    // Bus.
    input wire logic [ADDR_W-1:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    input wire logic [31:0] o_avs_readdata,
    input wire logic o_avs_waitrequest,
    // Converter and LED.
    input wire logic o_adc_active,
    input wire logic [1:0] o_range_sel,
    input wire logic o_ir_led_drive_out,
    input wire logic [1:0] o_led_current_sel
);
    logic [7:0] run_r;
    logic [7:0] last_r;
    logic ran_r;
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_b);
    ////////////////////////////////////////////////////////////////////////
    // Run lengths saturate, so a long steady drive never wraps into a short one.
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            run_r <= 8'h00;
            last_r <= 8'hFF;
            ran_r <= 1'b0;
        end else begin
            run_r <= $changed(o_ir_led_drive_out) ? 8'h01 : run_r + 8'(run_r != 8'hFF);
            if ($changed(o_ir_led_drive_out)) begin
                last_r <= run_r;
            end
            ran_r <= ran_r | o_adc_active;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    sequence req_s;
        (i_avs_read || i_avs_write) && o_avs_waitrequest;
    endsequence
    sequence ack_s;
        !o_avs_waitrequest ##1 o_avs_waitrequest;
    endsequence
    bus_answer_a: assert property ($rose(i_avs_read || i_avs_write) ##0 req_s |-> ##1 ack_s)
        else $error("bus answer not two cycles");
    data_zero_a: assert property (!ran_r && i_avs_read && !o_avs_waitrequest
        && i_avs_address[4:3] == 2'b01 |-> o_avs_readdata == 32'h00000000)
        else $error("data not zero before first conversion");
    start_cause_a: assert property ($rose(o_adc_active)
        |-> $past(i_avs_write) || $past(i_avs_write, 2) || $past(o_adc_active, 2))
        else $error("conversion started unbidden");
    pdown_hold_a: assert property ((!o_adc_active && !i_avs_write)[*2]
        |=> !o_adc_active) else $error("converter left power-down");
    led_idle_a: assert property ((!o_adc_active)[*3] |-> !o_ir_led_drive_out)
        else $error("led driven outside conversion");
    led_duty_a: assert property ($changed(o_ir_led_drive_out) && run_r <= 8'h08
        && last_r <= 8'h08 && o_adc_active |-> run_r == 8'(P_HALF_CYC))
        else $error("led half period wrong");
    led_cur_a: assert property (i_avs_write && !o_avs_waitrequest && i_avs_byteenable[0]
        && i_avs_address == ADDR_CMD2 |=> ##1 o_led_current_sel == $past(i_avs_writedata[7:6], 2))
        else $error("led current not applied");
    range_hold_a: assert property ($past(o_adc_active, 2) && $past(o_adc_active)
        && o_adc_active |-> $stable(o_range_sel)) else $error("range moved mid conversion");
endmodule : lpm_ctrl_asserts
bind lpm_ctrl lpm_ctrl_asserts #(.P_HALF_CYC(P_HALF_CYC)) lpm_ctrl_asserts_inst (.*);

// >>> sim/lpm_host_model.sv
// Purpose: Avalon-MM host that issues the register reads and writes.
// Assumes: One request at a time, opened just after a rising edge.
// Notes: An unanswered request ends the run through the bench.
`timescale 1ns/1ps
module lpm_host_model
    import lpm_pkg::*;
(
    // Clock.
    input wire logic i_ref_clk,
    // Requests.
    output logic [ADDR_W-1:0] o_avs_address,
    output logic o_avs_read,
    output logic o_avs_write,
    output logic [31:0] o_avs_writedata,
    output logic [3:0] o_avs_byteenable,
    // Answers.
    input wire logic [31:0] i_avs_readdata,
    input wire logic i_avs_waitrequest
);
    initial begin
        o_avs_address = 5'h00;
        o_avs_read = 1'b0;
        o_avs_write = 1'b0;
        o_avs_writedata = 32'h00000000;
        o_avs_byteenable = 4'h0;
    end
    task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [7:0] d,
            input logic [3:0] be, output logic [7:0] q);
        int n;
        n = 0;
        @(posedge i_ref_clk);
        o_avs_address <= a;
        o_avs_writedata <= {24'h000000, d};
        o_avs_byteenable <= be;
        o_avs_write <= w;
        o_avs_read <= !w;
        // Waitrequest and read data are taken at the rising edge that ends the wait.
        do begin
            @(posedge i_ref_clk);
            n++;
        end while (i_avs_waitrequest !== 1'b0 && n < 100);
        if (n >= 100) begin
            tb_top.hang_abort();
        end
        q = i_avs_readdata[7:0];
        o_avs_read <= 1'b0;
        o_avs_write <= 1'b0;
        o_avs_address <= ~a;
        o_avs_writedata <= ~o_avs_writedata;
    endtask : xfer
endmodule : lpm_host_model

// >>> sim/tb_top.sv
// Purpose: Self-checking bench of the light and proximity sequencer.
// Assumes: The 16-bit integration is shortened to 32 cycles.
// Notes: Front-end pulses are held steady over whole stretches.
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
    begin \
        checks++; \
        if ((got) !== (exp)) begin \
            err_total++; \
            $display("BAD %s expected %0h seen %0h", nm, exp, got); \
        end \
    end
module tb_top
    import lpm_pkg::*;
;
    logic i_ref_clk, i_rst_b, i_avs_read, i_avs_write, o_avs_waitrequest, i_adc_pulse;
    logic o_adc_active, o_ir_led_drive_out;
    logic [ADDR_W-1:0] i_avs_address;
    logic [31:0] i_avs_writedata, o_avs_readdata;
    logic [3:0] i_avs_byteenable;
    logic [1:0] o_adc_src, o_range_sel, o_led_current_sel;
    logic [15:0] exp_tab [4] = '{16'h0020, 16'h0FFF, 16'h00FF, 16'h000F};
    int err_total;
    int checks;
    lpm_ctrl #(.P_CYC_16(32), .P_HALF_CYC(2)) lpm_ctrl_inst (.*);
    lpm_host_model lpm_host_model_inst (.i_ref_clk, .o_avs_address(i_avs_address),
        .o_avs_read(i_avs_read), .o_avs_write(i_avs_write), .o_avs_writedata(i_avs_writedata),
        .o_avs_byteenable(i_avs_byteenable), .i_avs_readdata(o_avs_readdata),
        .i_avs_waitrequest(o_avs_waitrequest));
    ////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : tally_and_finish
    task automatic hang_abort();
        err_total++;
        $display("BAD wait expected answer seen timeout");
        tally_and_finish();
    endtask : hang_abort
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        logic [7:0] q;
        lpm_host_model_inst.xfer(1'b1, a, d, 4'h1, q);
    endtask : wr
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [7:0] q);
        lpm_host_model_inst.xfer(1'b0, a, 8'h00, 4'hF, q);
    endtask : rd
    task automatic rd16(output logic [15:0] v);
        rd(ADDR_DATA_LSB, v[7:0]);
        rd(ADDR_DATA_MSB, v[15:8]);
    endtask : rd16
    task automatic wait_lvl(input logic lvl);
        int n;
        n = 0;
        do begin
            @(negedge i_ref_clk);
            n++;
        end while (o_adc_active !== lvl && n < 6000);
        if (n >= 6000) begin
            hang_abort();
        end
    endtask : wait_lvl
    ////////////////////////////////////////////////////////////////////////
    initial begin
        i_ref_clk = 1'b0;
        forever #25 i_ref_clk = ~i_ref_clk;
    end
    initial begin
        logic [7:0] q;
        logic [15:0] v;
        err_total = 0;
        checks = 0;
        i_rst_b = 1'b0;
        i_adc_pulse = 1'b0;
        repeat (5) @(posedge i_ref_clk);
        i_rst_b <= 1'b1;
        rd16(v);
        `CHK("data at reset", 16'h0000, v)
        rd(5'h1C, q);
        `CHK("unmapped read", 8'h00, q)
        repeat (20) @(negedge i_ref_clk);
        `CHK("idle after reset", 1'b0, o_adc_active)
        $display("test reset done");
        @(posedge i_ref_clk);
        i_adc_pulse <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_CMD2, {2'(i), (i == 2) ? FREQ_MOD : FREQ_DC, 2'(i), 2'(i)});
            wr(ADDR_CMD1, {1'b0, (i < 2) ? 2'(i + 1) : SRC_PROX, 5'h00});
            wait_lvl(1'b1);
            repeat (3) @(negedge i_ref_clk);
            `CHK("range", 2'(i), o_range_sel)
            `CHK("source", (i < 2) ? 2'(i + 1) : SRC_PROX, o_adc_src)
            `CHK("led current", 2'(i), o_led_current_sel)
            `CHK("led drive", i == 3, o_ir_led_drive_out)
            wait_lvl(1'b0);
            repeat (20) @(negedge i_ref_clk);
            `CHK("auto power-down", 1'b0, o_adc_active)
            rd16(v);
            `CHK("result", exp_tab[i], v)
            $display("test conversion %0d done", i);
        end
        wr(ADDR_CMD1, 8'hC0);
        repeat (40) @(negedge i_ref_clk);
        `CHK("restart", 1'b1, o_adc_active)
        rd16(v);
        `CHK("continuous result", 16'h000F, v)
        @(posedge i_ref_clk);
        i_adc_pulse <= 1'b0;
        repeat (40) @(negedge i_ref_clk);
        rd16(v);
        `CHK("newest result", 16'h0000, v)
        wr(ADDR_CMD1, 8'h00);
        repeat (40) @(negedge i_ref_clk);
        `CHK("stopped", 1'b0, o_adc_active)
        $display("test continuous done");
        wr(ADDR_CTRL, 8'h01);
        wr(ADDR_CMD2, 8'h00);
        wr(ADDR_CMD1, 8'h20);
        repeat (10) @(negedge i_ref_clk);
        `CHK("armed idle", 1'b0, o_adc_active)
        wr(ADDR_EXT_TRIG, 8'h00);
        repeat (3) @(posedge i_ref_clk);
        i_adc_pulse <= 1'b1;
        repeat (10) @(posedge i_ref_clk);
        i_adc_pulse <= 1'b0;
        repeat (5) @(posedge i_ref_clk);
        wr(ADDR_EXT_TRIG, 8'h00);
        wait_lvl(1'b0);
        rd16(v);
        `CHK("external count", 16'h000A, v)
        wr(ADDR_CTRL, 8'h00);
        $display("test external done");
        wr(ADDR_CMD2, 8'h08);
        i_adc_pulse <= 1'b1;
        wr(ADDR_CMD1, 8'h20);
        repeat (20) @(posedge i_ref_clk);
        wr(ADDR_CMD1, 8'h80);
        repeat (10) @(negedge i_ref_clk);
        `CHK("reserved op idle", 1'b0, o_adc_active)
        rd16(v);
        `CHK("data kept", 16'h000A, v)
        lpm_host_model_inst.xfer(1'b1, ADDR_CMD1, 8'h20, 4'h0, q);
        repeat (10) @(negedge i_ref_clk);
        `CHK("masked write", 1'b0, o_adc_active)
        rd(ADDR_CMD1, q);
        `CHK("command kept", 8'h80, q)
        rd(ADDR_CMD2, q);
        `CHK("settings kept", 8'h08, q)
        $display("test abort done");
        tally_and_finish();
    end
endmodule : tb_top
